/* core/srwg_pkg.sv */
package srwg_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] ADDR_CONTROL = 12'h000;
  localparam logic [11:0] ADDR_STATUS  = 12'h004;
  localparam logic [11:0] ADDR_IRQ     = 12'h008;
  localparam logic [11:0] ADDR_MASK    = 12'h00C;

  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  localparam int CTL_SEL_LO   = 0;
  localparam int CTL_SEL_HI   = 1;
  localparam int CTL_LOCK_LO  = 2;
  localparam int CTL_LOCK_HI  = 3;
  localparam logic [1:0] SEL_RESET  = 2'h0;
  localparam logic [1:0] LOCK_RESET = 2'h0;
  localparam logic [1:0] LOCK_OPEN  = 2'h0;

  // ---------------------------------------------------------------
  // status and interrupt bits
  // ---------------------------------------------------------------
  localparam int ST_RESET_OUT = 0;
  localparam int ST_WP        = 1;
  localparam int ST_MON3      = 2;
  localparam int ST_SDA       = 3;
  localparam int EV_RESET_START = 0;
  localparam int EV_RESET_END   = 1;
  localparam int EV_REFUSED     = 2;
  localparam int EV_MON3_FAIL   = 3;
  localparam int EV_W           = 4;

  // ---------------------------------------------------------------
  // timing: hold times in microseconds, clock in MHz
  // ---------------------------------------------------------------
  localparam int CLK_MHZ     = 50;
  localparam int HOLD0_US    = 50000;
  localparam int HOLD1_US    = 200000;
  localparam int HOLD2_US    = 400000;
  localparam int HOLD3_US    = 800000;
  localparam int HOLD0_CYC   = HOLD0_US * CLK_MHZ;
  localparam int HOLD1_CYC   = HOLD1_US * CLK_MHZ;
  localparam int HOLD2_CYC   = HOLD2_US * CLK_MHZ;
  localparam int HOLD3_CYC   = HOLD3_US * CLK_MHZ;
  localparam int CNT_W       = 32;

  typedef logic [CNT_W-1:0] srwg_cnt_t;

  typedef enum logic [1:0] {
    SRWG_IDLE,
    SRWG_PRESS,
    SRWG_HOLD
  } srwg_state_e;

endpackage

/* core/srwg_wr_if.sv */
`timescale 1ns/1ps
interface srwg_wr_if;
  logic       wr_req;
  logic       wr_volatile;
  logic       protect_in;
  logic [1:0] lock;
  logic       wr_grant;
  logic       wr_refuse;

  modport guard (
    input  wr_req,
    input  wr_volatile,
    input  protect_in,
    input  lock,
    output wr_grant,
    output wr_refuse
  );
  modport user (
    output wr_req,
    output wr_volatile,
    output protect_in,
    output lock,
    input  wr_grant,
    input  wr_refuse
  );
endinterface

/* core/srwg_guard.sv */
`timescale 1ns/1ps
module srwg_guard (
  srwg_wr_if.guard g
);
  import srwg_pkg::*;

  logic locked;

  // RQ5: lock blocks all
  assign locked = g.protect_in && (g.lock != LOCK_OPEN);

  always_comb begin
    g.wr_grant  = 1'b0;
    g.wr_refuse = 1'b0;
    if (g.wr_req) begin
      // RQ4: protect blocks nonvolatile
      if (locked || (g.protect_in && !g.wr_volatile)) begin
        g.wr_refuse = 1'b1;
      end else begin
        g.wr_grant = 1'b1;
      end
    end
  end
endmodule

/* core/srwg_top.sv */
// Operation
// RQ1: a high manual reset input starts a reset cycle on the reset output.
// RQ2: the reset output stays high for the hold time after the input falls.
// RQ3: a two-bit control field chosen by software selects the hold time.
// RQ4: while write protect is high every nonvolatile write is refused.
// RQ5: with protect high and lock bits not zero, every write is refused.
// RQ6: an undriven write protect input counts as low.
// RQ7: the monitor fail output follows the comparator with no delay.
// RQ8: the serial data receiver is never gated off.
// RQ9: reasserting manual reset during the hold restarts it on release.
`timescale 1ns/1ps
module srwg_top #(
  parameter int HOLD0 = srwg_pkg::HOLD0_CYC,
  parameter int HOLD1 = srwg_pkg::HOLD1_CYC,
  parameter int HOLD2 = srwg_pkg::HOLD2_CYC,
  parameter int HOLD3 = srwg_pkg::HOLD3_CYC
) (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        MANUAL_RESET_IN,
  input  wire logic        PROTECT_IN,
  input  wire logic        PROTECT_DRIVEN,
  input  wire logic        MONITOR3_SENSE_IN,
  input  wire logic        SDA_IN,
  input  wire logic        WR_REQ,
  input  wire logic        WR_VOLATILE,
  output logic             WR_GRANT,
  output logic             WR_REFUSE,
  output logic             RESET_OUT,
  output logic             MONITOR3_FAIL_OUT,
  output logic             SDA_SEEN,
  output logic             IRQ,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR
);
  import srwg_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    srwg_state_e     state;
    srwg_cnt_t       cnt;
    logic            rst_out;
    logic [3:0]      control_reg;
    logic [EV_W-1:0] irq_stat;
    logic [EV_W-1:0] irq_mask;
    logic            mon_prev;
    logic [31:0]     rdata;
    logic            slverr;
  } srwg_regs_s;

  srwg_regs_s r;
  srwg_regs_s next_r;

  logic       protect_eff;
  logic       acc;
  logic       known;
  logic [1:0] sel;
  logic [EV_W-1:0] ev;

  srwg_wr_if wr ();

  function automatic srwg_cnt_t hold_cycles(input logic [1:0] s);
    unique case (s)
      2'h0:    hold_cycles = srwg_cnt_t'(HOLD0);
      2'h1:    hold_cycles = srwg_cnt_t'(HOLD1);
      2'h2:    hold_cycles = srwg_cnt_t'(HOLD2);
      default: hold_cycles = srwg_cnt_t'(HOLD3);
    endcase
  endfunction

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == ADDR_CONTROL) || (a == ADDR_STATUS) ||
                (a == ADDR_IRQ) || (a == ADDR_MASK);
  endfunction

  // ---------------------------------------------------------------
  // write guard
  // ---------------------------------------------------------------
  // RQ6: floating protect reads low
  assign protect_eff    = PROTECT_DRIVEN & PROTECT_IN;
  assign wr.wr_req      = WR_REQ;
  assign wr.wr_volatile = WR_VOLATILE;
  assign wr.protect_in  = protect_eff;
  assign wr.lock        = r.control_reg[CTL_LOCK_HI:CTL_LOCK_LO];

  srwg_guard u_guard (
    .g (wr)
  );

  assign WR_GRANT  = wr.wr_grant;
  assign WR_REFUSE = wr.wr_refuse;

  // ---------------------------------------------------------------
  // pass-through and register-driven outputs
  // ---------------------------------------------------------------
  // RQ7: no delay on fail
  assign MONITOR3_FAIL_OUT = MONITOR3_SENSE_IN;
  // RQ8: receiver never gated
  assign SDA_SEEN  = SDA_IN;
  assign RESET_OUT = r.rst_out;
  assign IRQ       = |(r.irq_stat & r.irq_mask);
  assign PRDATA    = r.rdata;
  assign PREADY    = 1'b1;
  assign PSLVERR   = r.slverr & PSEL & PENABLE;

  assign acc   = PSEL && PENABLE;
  assign known = is_mapped(PADDR);
  assign sel   = r.control_reg[CTL_SEL_HI:CTL_SEL_LO];

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_r = r;
    ev     = '0;

    unique case (r.state)
      SRWG_IDLE: begin
        // RQ1: manual reset starts cycle
        if (MANUAL_RESET_IN) begin
          next_r.state   = SRWG_PRESS;
          next_r.rst_out = 1'b1;
          ev[EV_RESET_START] = 1'b1;
        end
      end
      SRWG_PRESS: begin
        // RQ2: hold counted from release
        if (!MANUAL_RESET_IN) begin
          next_r.state = SRWG_HOLD;
          // RQ3: field picks hold
          next_r.cnt   = hold_cycles(sel);
        end
      end
      SRWG_HOLD: begin
        // RQ9: reassert restarts hold
        if (MANUAL_RESET_IN) begin
          next_r.state = SRWG_PRESS;
        end else if (r.cnt <= srwg_cnt_t'(1)) begin
          next_r.state   = SRWG_IDLE;
          next_r.rst_out = 1'b0;
          next_r.cnt     = '0;
          ev[EV_RESET_END] = 1'b1;
        end else begin
          next_r.cnt = r.cnt - srwg_cnt_t'(1);
        end
      end
    endcase

    ev[EV_REFUSED]   = wr.wr_refuse;
    next_r.mon_prev  = MONITOR3_SENSE_IN;
    ev[EV_MON3_FAIL] = MONITOR3_SENSE_IN & ~r.mon_prev;

    // apb: zero wait states, error on unmapped address
    next_r.slverr = PSEL && !known;
    next_r.rdata  = '0;
    if (PSEL && !PENABLE && !PWRITE) begin
      unique case (PADDR)
        ADDR_CONTROL: next_r.rdata = {28'h0, r.control_reg};
        ADDR_STATUS:  next_r.rdata = {28'h0, SDA_IN, MONITOR3_SENSE_IN,
                                      protect_eff, r.rst_out};
        ADDR_IRQ:     next_r.rdata = {28'h0, r.irq_stat};
        ADDR_MASK:    next_r.rdata = {28'h0, r.irq_mask};
        default:      next_r.rdata = '0;
      endcase
    end

    // set wins over write-one-to-clear
    next_r.irq_stat = r.irq_stat;
    if (acc && PWRITE && PADDR == ADDR_IRQ) begin
      next_r.irq_stat = r.irq_stat & ~PWDATA[EV_W-1:0];
    end
    next_r.irq_stat = next_r.irq_stat | ev;

    if (acc && PWRITE && PADDR == ADDR_CONTROL) begin
      next_r.control_reg = PWDATA[3:0];
    end
    if (acc && PWRITE && PADDR == ADDR_MASK) begin
      next_r.irq_mask = PWDATA[EV_W-1:0];
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      r <= '{state: SRWG_IDLE, cnt: '0, rst_out: 1'b0,
             control_reg: {LOCK_RESET, SEL_RESET}, irq_stat: '0,
             irq_mask: '0, mon_prev: 1'b0, rdata: '0, slverr: 1'b0};
    end else begin
      r <= next_r;
    end
  end
endmodule

/* verif/srwg_assertions.sv */
`timescale 1ns/1ps
module srwg_assertions (
  input wire logic CLK,
  input wire logic RST,
  input wire logic MANUAL_RESET_IN,
  input wire logic PROTECT_IN,
  input wire logic PROTECT_DRIVEN,
  input wire logic MONITOR3_SENSE_IN,
  input wire logic SDA_IN,
  input wire logic WR_REQ,
  input wire logic WR_VOLATILE,
  input wire logic WR_GRANT,
  input wire logic WR_REFUSE,
  input wire logic RESET_OUT,
  input wire logic MONITOR3_FAIL_OUT,
  input wire logic SDA_SEEN
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  wire logic prot = PROTECT_IN & PROTECT_DRIVEN;
  reset_start_a: assert property (MANUAL_RESET_IN |=> RESET_OUT)
    else $error("reset output not raised");
  hold_min_a: assert property ($fell(MANUAL_RESET_IN) |-> RESET_OUT[*3])
    else $error("reset output dropped early");
  hold_end_a: assert property ($fell(MANUAL_RESET_IN)
    |-> ##[1:40] (!RESET_OUT || MANUAL_RESET_IN)) else $error("hold too long");
  hold_restart_a: assert property (RESET_OUT && MANUAL_RESET_IN
    |=> RESET_OUT[*2]) else $error("reassert did not extend hold");
  nv_refuse_a: assert property (WR_REQ && prot && !WR_VOLATILE
    |-> WR_REFUSE && !WR_GRANT) else $error("protected write granted");
  open_grant_a: assert property (WR_REQ && !prot
    |-> WR_GRANT && !WR_REFUSE) else $error("open write refused");
  mon3_follow_a: assert property (MONITOR3_FAIL_OUT == MONITOR3_SENSE_IN)
    else $error("monitor output lags comparator");
  sda_open_a: assert property (SDA_SEEN == SDA_IN)
    else $error("serial data receiver gated");
endmodule
bind srwg_top srwg_assertions i_srwg_assertions (.CLK(CLK), .RST(RST),
  .MANUAL_RESET_IN(MANUAL_RESET_IN), .PROTECT_IN(PROTECT_IN),
  .PROTECT_DRIVEN(PROTECT_DRIVEN), .MONITOR3_SENSE_IN(MONITOR3_SENSE_IN),
  .SDA_IN(SDA_IN), .WR_REQ(WR_REQ), .WR_VOLATILE(WR_VOLATILE),
  .WR_GRANT(WR_GRANT), .WR_REFUSE(WR_REFUSE), .RESET_OUT(RESET_OUT),
  .MONITOR3_FAIL_OUT(MONITOR3_FAIL_OUT), .SDA_SEEN(SDA_SEEN));

/* verif/srwg_host.sv */
`timescale 1ns/1ps
module srwg_host (
  input  wire logic clk,
  output logic      mr,
  output logic      wp,
  output logic      wp_drv,
  output logic      sense,
  output logic      sda,
  output logic      wr,
  output logic      vol
);
  // released pins rest at their pull levels; a floating protect pin keeps
  // its stale level so only the driven flag can make it harmless
  initial begin
    {mr, wp, wp_drv, sense, wr, vol} = '0;
    sda = 1'b1;
  end
  task automatic press(input int n);
    @(posedge clk) mr <= 1'b1;
    repeat (n) @(posedge clk);
    mr <= 1'b0;
  endtask
  task automatic pins(input logic [5:0] v);
    @(posedge clk) {sense, sda, wp, wp_drv, wr, vol} <= v;
  endtask
endmodule

/* verif/srwg_top_tb.sv */
`timescale 1ns/1ps
module srwg_top_tb;
  import srwg_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, mr, wp, wp_drv, sense, sda, wr, vol;
  logic        grant, refuse, rst_out, fail3, sda_seen, irq;
  int          miscompares = 0, n_checks = 0, cyc = 0;
  always #10 clk = ~clk;
  srwg_top #(.HOLD0(4), .HOLD1(8), .HOLD2(16), .HOLD3(32)) i_srwg_top (
    .CLK(clk), .RST(rst), .MANUAL_RESET_IN(mr), .PROTECT_IN(wp),
    .PROTECT_DRIVEN(wp_drv), .MONITOR3_SENSE_IN(sense), .SDA_IN(sda),
    .WR_REQ(wr), .WR_VOLATILE(vol), .WR_GRANT(grant), .WR_REFUSE(refuse),
    .RESET_OUT(rst_out), .MONITOR3_FAIL_OUT(fail3), .SDA_SEEN(sda_seen),
    .IRQ(irq), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr));
  srwg_host i_srwg_host (.clk(clk), .mr(mr), .wp(wp), .wp_drv(wp_drv),
    .sense(sense), .sda(sda), .wr(wr), .vol(vol));
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk) penable <= 1'b1;
    // read data stands only in the access cycle: take it at the ready edge
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // cycles from release of manual reset until the reset output drops
  task automatic measure(output int n);
    n = 0;
    while (rst_out === 1'b1 && n < 60) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic t_regs;
    apb(0, ADDR_CONTROL, 0);
    chk("control reset", rd, 32'h0);
    apb(0, ADDR_STATUS, 0);
    chk("status idle", rd, 32'h8);
    apb(1, 12'h010, 32'hF);
    chk("unmapped err", 32'(err), 32'h1);
    apb(0, 12'h010, 0);
    chk("unmapped read", rd, 32'h0);
  endtask
  task automatic t_hold;
    int n;
    for (int s = 0; s < 4; s++) begin
      apb(1, ADDR_CONTROL, s);
      i_srwg_host.press(3);
      chk("reset raised", 32'(rst_out), 32'h1);
      measure(n);
      chk("hold length", 32'(n >= 4 << s && n <= (4 << s) + 3), 1);
    end
  endtask
  task automatic t_restart;
    int n;
    apb(1, ADDR_CONTROL, 32'h3);
    i_srwg_host.press(2);
    repeat (6) @(posedge clk);
    i_srwg_host.press(2);
    chk("still held", 32'(rst_out), 32'h1);
    measure(n);
    chk("hold restarted", 32'(n >= 32), 32'h1);
  endtask
  task automatic t_guard;
    logic exp;
    for (int i = 0; i < 16; i++) begin
      apb(1, ADDR_CONTROL, i[1] ? 32'h8 : 32'h0);
      i_srwg_host.pins({i[0], i[1], i[3], i[2], 1'b1, i[0]});
      exp = i[3] & i[2] & (i[1] | !i[0]);
      @(negedge clk);
      chk("refuse", 32'(refuse), 32'(exp));
      chk("grant", 32'(grant), 32'(!exp));
    end
    i_srwg_host.pins(6'h10);
  endtask
  task automatic t_irq;
    apb(1, ADDR_MASK, 0);
    @(negedge clk) chk("irq masked", 32'(irq), 32'h0);
    apb(1, ADDR_MASK, 32'h1);
    @(negedge clk) chk("irq raised", 32'(irq), 32'h1);
    apb(1, ADDR_IRQ, 32'h1);
    @(negedge clk) chk("irq cleared", 32'(irq), 32'h0);
    apb(0, ADDR_IRQ, 0);
    chk("sticky kept", rd & 32'h6, 32'h6);
  endtask
  task automatic report_and_stop;
    if (miscompares == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_hold;
    t_restart;
    t_guard;
    t_irq;
    report_and_stop;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      report_and_stop;
    end
  end
endmodule
